// File: verilog/dpram_defs.vh
// Purpose: shared constants of the dual-port synchronous static memory
// Assumes: one system clock drives both ports
// Notes: included by every design file of the memory
//
// Summary of operation
// R1: Two independent ports may reach any location, the same one included, in the same cycle.
// R2: The array holds 131072 words of 8 bits, with a 17-bit address and an 8-bit data bus per port.
// R3: Each port captures address, write data and controls in input registers on the rising clock edge.
// R4: A port whose low select is high or whose high select is low is deselected, undriven and idle.
// R5: A deselected port sits in a standby state that only its two selects control.
// R6: A selected port with write-not-read low at the edge writes the captured data, whatever output enable is.
// R7: A selected port with write-not-read high and output enable low drives the addressed word.
// R8: Output enable high releases the data bus at once, independent of the clock.
// R9: Counter clear low at an edge sets the address counter to zero and uses address zero.
// R10: With clear high and load strobe low the external address is loaded and used, whatever advance and selects are.
// R11: With clear, load strobe and advance all high the external address is ignored and the last address reused.
// R12: With clear and strobe high and advance low the internal address steps by one, whatever the selects are.
// R13: Each port chooses flow-through or pipelined output by its own latency select input.
// R14: In pipelined mode read data appears one cycle later than in flow-through mode.
// R15: The outside party holds write-not-read high while it loads an external address.
// R16: The address counter wraps from its highest value to zero.
// R17: The outside party does not write one location from both ports in one cycle.
`ifndef DPRAM_DEFS_VH
`define DPRAM_DEFS_VH

`define ADDR_W 17
`define DATA_W 8
`define MEM_DEPTH 131072
`define MEM_LAST 131071
`define ADDR_ZERO 17'h00000
`define ADDR_STEP 17'h00001
`define DATA_ZERO 8'h00
`define LAT_PIPELINED 1'b1

`endif

// File: verilog/ram_port_front.v
// Purpose: input registers and burst address counter of one memory port
// Assumes: inputs synchronous to CLK_SYS
// Notes: the captured address, data and access kind feed the array stage
`timescale 1ns/100ps
`include "dpram_defs.vh"

module ram_port_front (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // selects and access kind
    input wire select_low_active_n,
    input wire select_high_active,
    input wire write_not_read,
    // address counter control
    input wire address_load_strobe_n,
    input wire counter_advance_n,
    input wire counter_clear_n,
    // address and write data
    input wire [`ADDR_W-1:0] word_address,
    input wire [`DATA_W-1:0] data_in,
    // captured access
    output reg [`ADDR_W-1:0] access_address,
    output reg [`DATA_W-1:0] access_data,
    output reg access_write,
    output reg access_read,
    output reg standby
);

    wire selected;
    reg [`ADDR_W-1:0] next_address;

    // both selects must agree; anything else deselects the port
    assign selected = ~select_low_active_n & select_high_active; // [R4]

    // counter control is priority coded and ignores the selects
    always @* begin
        if (!counter_clear_n) begin
            next_address = `ADDR_ZERO; // [R9]
        end else if (!address_load_strobe_n) begin
            next_address = word_address; // [R10]
        end else if (!counter_advance_n) begin
            // carry out is dropped so the counter wraps to zero
            next_address = access_address + `ADDR_STEP; // [R12] [R16]
        end else begin
            next_address = access_address; // [R11]
        end
    end

    // input registers: one capture per edge on every edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            access_address <= `ADDR_ZERO;
            access_data <= `DATA_ZERO;
            access_write <= 1'b0;
            access_read <= 1'b0;
            standby <= 1'b1;
        end else begin
            access_address <= next_address; // [R3]
            access_data <= data_in; // [R3]
            access_write <= selected & ~write_not_read; // [R6]
            access_read <= selected & write_not_read; // [R7]
            standby <= ~selected; // [R5]
        end
    end

endmodule

// File: verilog/dual_port_ram.v
// Purpose: synchronous dual-port static memory, 128K words of 8 bits
// Assumes: both ports run on CLK_SYS; inputs synchronous to it
// Notes: data bus is split into in, out and enable; enable high drives
//   the bus enable is the one output not taken straight from a flop,
//   since output enable must act with no clock in its path
//   array words are not reset and read as unknown until written
`timescale 1ns/100ps
`include "dpram_defs.vh"

module dual_port_ram (
    // clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // port A selects and access kind
    input wire A_SELECT_LOW_ACTIVE_N,
    input wire A_SELECT_HIGH_ACTIVE,
    input wire A_WRITE_NOT_READ,
    input wire A_OUTPUT_ENABLE_N,
    // port A address counter control and output latency select
    input wire A_ADDRESS_LOAD_STROBE_N,
    input wire A_COUNTER_ADVANCE_N,
    input wire A_COUNTER_CLEAR_N,
    input wire A_OUTPUT_LATENCY_SELECT,
    // port A address and write data
    input wire [`ADDR_W-1:0] A_WORD_ADDRESS,
    input wire [`DATA_W-1:0] A_DATA_BUS_IN,
    // port A read data, bus enable and standby
    output reg [`DATA_W-1:0] A_DATA_BUS_OUT,
    output wire A_DATA_BUS_OE,
    output wire A_STANDBY,
    // port B selects and access kind
    input wire B_SELECT_LOW_ACTIVE_N,
    input wire B_SELECT_HIGH_ACTIVE,
    input wire B_WRITE_NOT_READ,
    input wire B_OUTPUT_ENABLE_N,
    // port B address counter control and output latency select
    input wire B_ADDRESS_LOAD_STROBE_N,
    input wire B_COUNTER_ADVANCE_N,
    input wire B_COUNTER_CLEAR_N,
    input wire B_OUTPUT_LATENCY_SELECT,
    // port B address and write data
    input wire [`ADDR_W-1:0] B_WORD_ADDRESS,
    input wire [`DATA_W-1:0] B_DATA_BUS_IN,
    // port B read data, bus enable and standby
    output reg [`DATA_W-1:0] B_DATA_BUS_OUT,
    output wire B_DATA_BUS_OE,
    output wire B_STANDBY
);

    // shared array, reachable from both ports at once
    reg [`DATA_W-1:0] mem [0:`MEM_LAST]; // [R2]

    // captured access of port A
    wire [`ADDR_W-1:0] a_addr;
    wire [`DATA_W-1:0] a_wdata;
    wire a_write;
    wire a_read;

    // captured access of port B
    wire [`ADDR_W-1:0] b_addr;
    wire [`DATA_W-1:0] b_wdata;
    wire b_write;
    wire b_read;

    // port A read stages: pipeline stage and driving flags
    reg [`DATA_W-1:0] a_stage;
    reg a_stage_drive;
    reg a_drive;

    // port B read stages: pipeline stage and driving flags
    reg [`DATA_W-1:0] b_stage;
    reg b_stage_drive;
    reg b_drive;

    // array word on each port's captured address
    wire [`DATA_W-1:0] a_word;
    wire [`DATA_W-1:0] b_word;

    // pick the word for the output register by latency mode
    function [`DATA_W-1:0] pick_data;
        input pipelined;
        input [`DATA_W-1:0] staged;
        input [`DATA_W-1:0] fresh;
        begin
            if (pipelined == `LAT_PIPELINED) begin
                pick_data = staged;
            end else begin
                pick_data = fresh;
            end
        end
    endfunction

    // pick the drive flag for the output register by latency mode
    function pick_drive;
        input pipelined;
        input staged;
        input fresh;
        begin
            if (pipelined == `LAT_PIPELINED) begin
                pick_drive = staged;
            end else begin
                pick_drive = fresh;
            end
        end
    endfunction

    // gate a registered drive flag with the asynchronous output enable
    function bus_enable;
        input drive;
        input enable_n;
        begin
            bus_enable = drive & ~enable_n;
        end
    endfunction

    // port A front end: input registers and address counter
    ram_port_front u_front_a (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .select_low_active_n(A_SELECT_LOW_ACTIVE_N),
        .select_high_active(A_SELECT_HIGH_ACTIVE),
        .write_not_read(A_WRITE_NOT_READ),
        .address_load_strobe_n(A_ADDRESS_LOAD_STROBE_N),
        .counter_advance_n(A_COUNTER_ADVANCE_N),
        .counter_clear_n(A_COUNTER_CLEAR_N),
        .word_address(A_WORD_ADDRESS),
        .data_in(A_DATA_BUS_IN),
        .access_address(a_addr),
        .access_data(a_wdata),
        .access_write(a_write),
        .access_read(a_read),
        .standby(A_STANDBY)
    );

    // port B front end: input registers and address counter
    ram_port_front u_front_b (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .select_low_active_n(B_SELECT_LOW_ACTIVE_N),
        .select_high_active(B_SELECT_HIGH_ACTIVE),
        .write_not_read(B_WRITE_NOT_READ),
        .address_load_strobe_n(B_ADDRESS_LOAD_STROBE_N),
        .counter_advance_n(B_COUNTER_ADVANCE_N),
        .counter_clear_n(B_COUNTER_CLEAR_N),
        .word_address(B_WORD_ADDRESS),
        .data_in(B_DATA_BUS_IN),
        .access_address(b_addr),
        .access_data(b_wdata),
        .access_write(b_write),
        .access_read(b_read),
        .standby(B_STANDBY)
    );

    // both ports read the array without waiting on each other
    assign a_word = mem[a_addr]; // [R1]
    assign b_word = mem[b_addr]; // [R1]

    // array writes; B is written last, so a same-word clash keeps B
    always @(posedge CLK_SYS) begin
        // port A write of its captured word
        if (a_write) begin
            mem[a_addr] <= a_wdata; // [R6] [R1]
        end
        // port B write; the hosts never write one word from both ports at once
        if (b_write) begin
            mem[b_addr] <= b_wdata; // [R6] [R1] [R17]
        end
    end

    // port A stage register: holds the extra cycle of pipelined mode
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            a_stage <= `DATA_ZERO;
            a_stage_drive <= 1'b0;
        end else begin
            a_stage <= a_word; // [R14]
            a_stage_drive <= a_read; // [R14]
        end
    end

    // port A output register: the latency select picks its source
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            A_DATA_BUS_OUT <= `DATA_ZERO;
            a_drive <= 1'b0;
        end else begin
            // pipelined mode takes the stage, one cycle behind
            A_DATA_BUS_OUT <= pick_data(A_OUTPUT_LATENCY_SELECT,
                a_stage, a_word); // [R13] [R14]
            // the drive flag follows the data, so a write never drives
            a_drive <= pick_drive(A_OUTPUT_LATENCY_SELECT,
                a_stage_drive, a_read); // [R7] [R4] [R14]
        end
    end

    // port B stage register: holds the extra cycle of pipelined mode
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            b_stage <= `DATA_ZERO;
            b_stage_drive <= 1'b0;
        end else begin
            b_stage <= b_word; // [R14]
            b_stage_drive <= b_read; // [R14]
        end
    end

    // port B output register: the latency select picks its source
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            B_DATA_BUS_OUT <= `DATA_ZERO;
            b_drive <= 1'b0;
        end else begin
            // pipelined mode takes the stage, one cycle behind
            B_DATA_BUS_OUT <= pick_data(B_OUTPUT_LATENCY_SELECT,
                b_stage, b_word); // [R13] [R14]
            // the drive flag follows the data, so a write never drives
            b_drive <= pick_drive(B_OUTPUT_LATENCY_SELECT,
                b_stage_drive, b_read); // [R7] [R4] [R14]
        end
    end

    // output enable gates the drive with no clock in the path
    assign A_DATA_BUS_OE = bus_enable(a_drive,
        A_OUTPUT_ENABLE_N); // [R8] [R7]
    assign B_DATA_BUS_OE = bus_enable(b_drive,
        B_OUTPUT_ENABLE_N); // [R8] [R7]

endmodule

// File: sim/dual_port_ram_props.sv
// Purpose: concurrent checks on the ports of the dual-port memory
// Assumes: flow-through when the latency select is low
// Notes: watches drive, release and standby of port A and the selects and release of port B
`timescale 1ns/100ps
module dual_port_ram_props (
    // clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // port A
    input wire A_SELECT_LOW_ACTIVE_N,
    input wire A_SELECT_HIGH_ACTIVE,
    input wire A_WRITE_NOT_READ,
    input wire A_OUTPUT_ENABLE_N,
    input wire A_OUTPUT_LATENCY_SELECT,
    input wire A_DATA_BUS_OE,
    input wire A_STANDBY,
    // port B
    input wire B_SELECT_LOW_ACTIVE_N,
    input wire B_SELECT_HIGH_ACTIVE,
    input wire B_OUTPUT_ENABLE_N,
    input wire B_DATA_BUS_OE,
    input wire B_STANDBY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // decoded selects and mode
    wire a_sel = !A_SELECT_LOW_ACTIVE_N && A_SELECT_HIGH_ACTIVE;
    wire b_sel = !B_SELECT_LOW_ACTIVE_N && B_SELECT_HIGH_ACTIVE;
    wire a_ft = !A_OUTPUT_LATENCY_SELECT;
    wire a_rd = a_sel && A_WRITE_NOT_READ;
    // read steps: capture, output stage(s), enable low
    sequence ft_read;
        a_rd && a_ft ##1 a_ft ##1 !A_OUTPUT_ENABLE_N;
    endsequence
    sequence pp_read;
        a_rd && !a_ft ##1 !a_ft [*2] ##1 !A_OUTPUT_ENABLE_N;
    endsequence
    release_a_a: assert property (A_OUTPUT_ENABLE_N |-> !A_DATA_BUS_OE)
        else $error("port A drives with enable high");
    release_b_a: assert property (B_OUTPUT_ENABLE_N |-> !B_DATA_BUS_OE)
        else $error("port B drives with enable high");
    idle_nodrv_a: assert property (!a_sel && a_ft ##1 a_ft |=> !A_DATA_BUS_OE)
        else $error("deselected cycle drove the bus");
    write_nodrv_a: assert property (
        a_sel && !A_WRITE_NOT_READ && a_ft ##1 a_ft |=> !A_DATA_BUS_OE)
        else $error("write cycle drove the bus");
    read_drive_a: assert property (ft_read |-> A_DATA_BUS_OE)
        else $error("flow-through read not driven");
    pipe_drive_a: assert property (pp_read |-> A_DATA_BUS_OE)
        else $error("pipelined read not driven");
    pipe_late_a: assert property (
        !a_rd && !a_ft ##1 a_rd && !a_ft ##1 !a_ft |=> !A_DATA_BUS_OE)
        else $error("pipelined read came early");
    standby_a_a: assert property (!a_sel |=> A_STANDBY)
        else $error("port A not in standby");
    awake_a_a: assert property (a_sel |=> !A_STANDBY)
        else $error("port A standby while selected");
    standby_b_a: assert property (!b_sel |=> B_STANDBY)
        else $error("port B not in standby");
endmodule

bind dual_port_ram dual_port_ram_props dual_port_ram_props_inst (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .A_SELECT_LOW_ACTIVE_N(A_SELECT_LOW_ACTIVE_N),
    .A_SELECT_HIGH_ACTIVE(A_SELECT_HIGH_ACTIVE),
    .A_WRITE_NOT_READ(A_WRITE_NOT_READ), .A_STANDBY(A_STANDBY),
    .A_OUTPUT_ENABLE_N(A_OUTPUT_ENABLE_N), .A_DATA_BUS_OE(A_DATA_BUS_OE),
    .A_OUTPUT_LATENCY_SELECT(A_OUTPUT_LATENCY_SELECT),
    .B_SELECT_LOW_ACTIVE_N(B_SELECT_LOW_ACTIVE_N),
    .B_SELECT_HIGH_ACTIVE(B_SELECT_HIGH_ACTIVE), .B_STANDBY(B_STANDBY),
    .B_OUTPUT_ENABLE_N(B_OUTPUT_ENABLE_N), .B_DATA_BUS_OE(B_DATA_BUS_OE));

// File: sim/host_bus_model.sv
// Purpose: host side of one data bus, resolving the shared wire
// Assumes: host drives only while it writes
// Notes: an undriven wire shows a pattern that changes every cycle
`timescale 1ns/100ps
module host_bus_model (
    input wire clk,
    input wire dev_oe,
    input wire [7:0] dev_data,
    input wire host_oe,
    input wire [7:0] host_data,
    output wire [7:0] bus
);
    reg [7:0] last = 8'h00;
    // host releases the bus for reads, so a read nobody drives fails
    assign bus = dev_oe ? dev_data : (host_oe ? host_data : ~last);
    always @(posedge clk) begin
        last <= bus;
    end
endmodule

// File: sim/dual_port_ram_test.sv
// Purpose: directed tests of the dual-port memory
// Assumes: inputs change at the falling edge
// Notes: index 0 is port A, index 1 is port B
`timescale 1ns/100ps
module dual_port_ram_test;
    reg CLK_SYS = 1'b0;
    reg RST_N = 1'b0;
    reg [1:0] sl_n = 2'h3, sh = 2'h3, wnr = 2'h3, oe_n = 2'h0, hdrv = 2'h0;
    reg [1:0] ld_n = 2'h3, adv_n = 2'h3, clr_n = 2'h3, lat = 2'h0;
    reg [16:0] adr [0:1];
    reg [7:0] din [0:1];
    wire [7:0] bus [0:1];
    wire [7:0] dout [0:1];
    wire [1:0] oe, sby;
    int fail_count = 0;
    int total_checks = 0;
    always #5 CLK_SYS = ~CLK_SYS;
    dual_port_ram dual_port_ram_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .A_SELECT_LOW_ACTIVE_N(sl_n[0]), .A_SELECT_HIGH_ACTIVE(sh[0]),
        .A_WRITE_NOT_READ(wnr[0]), .A_OUTPUT_ENABLE_N(oe_n[0]),
        .A_ADDRESS_LOAD_STROBE_N(ld_n[0]), .A_COUNTER_ADVANCE_N(adv_n[0]),
        .A_COUNTER_CLEAR_N(clr_n[0]), .A_OUTPUT_LATENCY_SELECT(lat[0]),
        .A_WORD_ADDRESS(adr[0]), .A_DATA_BUS_IN(bus[0]),
        .A_DATA_BUS_OUT(dout[0]), .A_DATA_BUS_OE(oe[0]), .A_STANDBY(sby[0]),
        .B_SELECT_LOW_ACTIVE_N(sl_n[1]), .B_SELECT_HIGH_ACTIVE(sh[1]),
        .B_WRITE_NOT_READ(wnr[1]), .B_OUTPUT_ENABLE_N(oe_n[1]),
        .B_ADDRESS_LOAD_STROBE_N(ld_n[1]), .B_COUNTER_ADVANCE_N(adv_n[1]),
        .B_COUNTER_CLEAR_N(clr_n[1]), .B_OUTPUT_LATENCY_SELECT(lat[1]),
        .B_WORD_ADDRESS(adr[1]), .B_DATA_BUS_IN(bus[1]),
        .B_DATA_BUS_OUT(dout[1]), .B_DATA_BUS_OE(oe[1]), .B_STANDBY(sby[1]));
    host_bus_model host_a (.clk(CLK_SYS), .dev_oe(oe[0]), .dev_data(dout[0]),
        .host_oe(hdrv[0]), .host_data(din[0]), .bus(bus[0]));
    host_bus_model host_b (.clk(CLK_SYS), .dev_oe(oe[1]), .dev_data(dout[1]),
        .host_oe(hdrv[1]), .host_data(din[1]), .bus(bus[1]));
    // one captured cycle: select, access kind, counter control, data
    task automatic op(input int p, input logic s, w, l, a, c,
            input logic [16:0] ad, input logic [7:0] d);
        @(negedge CLK_SYS);
        sl_n[p] = !s;
        sh[p] = 1'b1;
        wnr[p] = w;
        hdrv[p] = !w;
        ld_n[p] = l;
        adv_n[p] = a;
        clr_n[p] = c;
        adr[p] = ad;
        din[p] = d;
    endtask
    task automatic idle(input int p);
        op(p, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 17'h00000, 8'h00);
    endtask
    task automatic chk(input string m, input logic [7:0] g, e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, m, g, e);
        end
    endtask
    // read, then wait out the latency of the port
    task automatic rd(input int p, input logic l, c, input logic [16:0] ad,
            input logic [7:0] e);
        op(p, 1'b1, 1'b1, l, 1'b1, c, ad, 8'h00);
        idle(p);
        chk("awake", 8'(sby[p]), 8'h00);
        repeat (lat[p]) begin
            @(negedge CLK_SYS);
            chk("early drive", 8'(oe[p]), 8'h00);
        end
        @(negedge CLK_SYS);
        chk("drive", 8'(oe[p]), 8'h01);
        chk("read data", dout[p], e);
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog against a hung run
    initial begin
        #5000;
        fail_count++;
        final_report;
    end
    // main sequence
    initial begin
        adr[0] = 17'h00000;
        adr[1] = 17'h00000;
        din[0] = 8'h00;
        din[1] = 8'h00;
        repeat (5) @(negedge CLK_SYS);
        RST_N = 1'b1;
        // load deselected: a read here would drive the bus into the write
        op(0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 17'h1FFFE, 8'h00);
        op(0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 17'h00000, 8'h11);
        op(0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 17'h00000, 8'h22);
        op(0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 17'h00000, 8'h33);
        idle(0);
        rd(1, 1'b0, 1'b1, 17'h1FFFE, 8'h11);
        rd(1, 1'b0, 1'b1, 17'h1FFFF, 8'h22);
        rd(1, 1'b0, 1'b0, 17'h1FFFF, 8'h33);
        lat[0] = 1'b1;
        rd(0, 1'b0, 1'b1, 17'h1FFFF, 8'h22);
        lat[0] = 1'b0;
        op(0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 17'h1FFFE, 8'h00);
        op(0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 17'h00000, 8'h55);
        idle(0);
        chk("standby", 8'(sby[0]), 8'h01);
        rd(0, 1'b1, 1'b1, 17'h00000, 8'h11);
        // both ports read one word at once; only reads, never two writes
        lat[1] = 1'b1;
        fork
            rd(0, 1'b0, 1'b1, 17'h1FFFE, 8'h11);
            rd(1, 1'b0, 1'b1, 17'h1FFFE, 8'h11);
        join
        oe_n[0] = 1'b1;
        op(0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 17'h1FFFF, 8'h00);
        idle(0);
        @(negedge CLK_SYS);
        chk("released", 8'(oe[0]), 8'h00);
        oe_n[0] = 1'b0;
        #1;
        chk("enabled", 8'(oe[0]), 8'h01);
        chk("late data", dout[0], 8'h22);
        final_report;
    end
endmodule
